// file: logic/pll_pkg.sv
package pll_pkg;

    // Clock rates; the slow clock is an enable pulse derived from mclk.
    localparam int MCLK_HZ = 50_000_000;
    localparam int SLOW_HZ = 32_768;
    localparam int SLOW_DIV_CYCLES = MCLK_HZ / SLOW_HZ;

    // Field widths of the loop configuration.
    localparam int DIV_WIDTH = 8;
    localparam int MUL_WIDTH = 11;
    localparam int CNT_WIDTH = 6;

    // Divider limits.
    localparam int DIV_MIN = 1;
    localparam int DIV_MAX = 255;

    // Slow clock ticks between a disable command and the real shutdown.
    localparam logic [1:0] STOP_DELAY_TICKS = 2'h2;

    // Reset values of the configuration fields.
    localparam logic [DIV_WIDTH-1:0] DIV_RESET = 8'h00;
    localparam logic [MUL_WIDTH-1:0] MUL_RESET = 11'h000;
    localparam logic [CNT_WIDTH-1:0] CNT_RESET = 6'h00;

    // Second loop source selection.
    localparam logic SRC_MAIN_DIVIDED = 1'b0;
    localparam logic SRC_FIRST_LOOP = 1'b1;

    typedef enum logic [1:0] {
        LOOP_OFF = 2'b00,
        LOOP_STOPPING = 2'b01,
        LOOP_RUN = 2'b10
    } loop_state_e;

endpackage

// file: logic/mult_loop.sv
`timescale 1ns/1ps
module mult_loop
    import pll_pkg::*;
#(
    parameter int DIV_W = DIV_WIDTH,
    parameter int MUL_W = MUL_WIDTH,
    parameter int CNT_W = CNT_WIDTH
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic slow_tick,
    input wire logic src_tick,
    input wire logic [DIV_W-1:0] div_val,
    input wire logic [MUL_W-1:0] mul_val,
    input wire logic [CNT_W-1:0] count_val,
    input wire logic start_pulse,
    input wire logic stop_pulse,
    output logic div_tick_q,
    output logic loop_tick_q,
    output logic powered_q,
    output logic locked_q
);

    localparam int ACC_W = DIV_W + MUL_W + 1;

    loop_state_e state_q;
    logic [1:0] stop_cnt_q;
    logic [DIV_W-1:0] div_cnt_q;
    logic [CNT_W-1:0] lock_cnt_q;
    logic counting_q;
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic div_zero;
    logic emit;

    assign div_zero = (div_val == '0);
    assign emit = powered_q && !div_zero && (acc_q != '0);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= LOOP_OFF;
            stop_cnt_q <= 2'h0;
        end else if (start_pulse) begin
            state_q <= LOOP_RUN;
        end else if (stop_pulse && state_q == LOOP_RUN) begin
            state_q <= LOOP_STOPPING;
            stop_cnt_q <= STOP_DELAY_TICKS;
        end else if (state_q == LOOP_STOPPING && slow_tick) begin
            if (stop_cnt_q <= 2'h1) begin
                state_q <= LOOP_OFF;
            end
            stop_cnt_q <= stop_cnt_q - 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            powered_q <= 1'b0;
        end else begin
            powered_q <= (state_q != LOOP_OFF);
        end
    end

    // A restart wins over a lock event in the same cycle, since the new settings have not settled yet.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lock_cnt_q <= CNT_RESET;
            counting_q <= 1'b0;
            locked_q <= 1'b0;
        end else if (start_pulse) begin
            lock_cnt_q <= count_val;
            counting_q <= 1'b1;
            locked_q <= 1'b0;
        end else if (stop_pulse) begin
            counting_q <= 1'b0;
            locked_q <= 1'b0;
        end else if (slow_tick && counting_q && state_q == LOOP_RUN) begin
            if (lock_cnt_q <= CNT_W'(1)) begin
                lock_cnt_q <= '0;
                counting_q <= 1'b0;
                locked_q <= 1'b1;
            end else begin
                lock_cnt_q <= lock_cnt_q - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_q <= '0;
            div_tick_q <= 1'b0;
        end else if (div_zero) begin
            div_cnt_q <= '0;
            div_tick_q <= 1'b0;
        end else if (src_tick) begin
            if (div_cnt_q >= div_val - DIV_W'(1)) begin
                div_cnt_q <= '0;
                div_tick_q <= 1'b1;
            end else begin
                div_cnt_q <= div_cnt_q + DIV_W'(1);
                div_tick_q <= 1'b0;
            end
        end else begin
            div_tick_q <= 1'b0;
        end
    end

    // Rate multiplier: each divided tick adds (mul+1) and each output pulse takes one away.
    // The division by div is already done in front, so the pulse rate is src*(mul+1)/div.
    // The output cannot exceed one pulse per mclk, so the accumulator skips additions while its top bit is set instead of wrapping.
    always_comb begin
        acc_d = acc_q;
        if (emit) begin
            acc_d = acc_d - ACC_W'(1);
        end
        if (div_tick_q && !acc_q[ACC_W-1]) begin
            acc_d = acc_d + ACC_W'(mul_val) + ACC_W'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            acc_q <= '0;
            loop_tick_q <= 1'b0;
        end else if (!powered_q || div_zero) begin
            acc_q <= '0;
            loop_tick_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            loop_tick_q <= emit;
        end
    end

endmodule

// file: logic/pll_divider_lock_logic.sv
`timescale 1ns/1ps
module pll_divider_lock_logic
    import pll_pkg::*;
#(
    parameter int DIV_W = DIV_WIDTH,
    parameter int MUL_W = MUL_WIDTH,
    parameter int CNT_W = CNT_WIDTH,
    parameter int SLOW_CYCLES = SLOW_DIV_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic main_clock,
    input wire logic [DIV_W-1:0] first_loop_divide_factor,
    input wire logic [MUL_W-1:0] first_loop_multiply_factor,
    input wire logic first_loop_enable_bit,
    input wire logic [CNT_W-1:0] first_loop_lock_wait_count,
    input wire logic first_loop_cfg_wr,
    input wire logic first_loop_lock_irq_en,
    input wire logic [DIV_W-1:0] second_loop_divide_factor,
    input wire logic [MUL_W-1:0] second_loop_multiply_factor,
    input wire logic [CNT_W-1:0] second_loop_lock_wait_count,
    input wire logic second_loop_source_sel,
    input wire logic second_loop_cfg_wr,
    input wire logic second_loop_lock_irq_en,
    output logic slow_clock,
    output logic first_loop_div_out,
    output logic first_multiplier_loop,
    output logic first_loop_powered,
    output logic first_loop_locked_flag,
    output logic second_loop_div_out,
    output logic second_multiplier_loop,
    output logic second_loop_powered,
    output logic second_loop_locked_flag,
    output logic lock_irq
);

    localparam int SLOW_CNT_W = $clog2(SLOW_CYCLES + 1);

    logic [SLOW_CNT_W-1:0] slow_cnt_q;
    logic slow_tick_q;
    logic main_sync1_q;
    logic main_sync2_q;
    logic main_prev_q;
    logic main_tick;

    logic [DIV_W-1:0] a_div_q;
    logic [MUL_W-1:0] a_mul_q;
    logic a_en_q;
    logic [CNT_W-1:0] a_cnt_q;
    logic a_start_q;
    logic a_stop_q;
    logic a_on_new;
    logic a_on_old;
    logic a_changed;

    logic [DIV_W-1:0] b_div_q;
    logic [MUL_W-1:0] b_mul_q;
    logic [CNT_W-1:0] b_cnt_q;
    logic b_sel_q;
    logic b_start_q;
    logic b_stop_q;
    logic b_on_new;
    logic b_changed;

    logic a_div_tick;
    logic a_loop_tick;
    logic a_powered;
    logic a_locked;
    logic b_src_tick;
    logic b_div_tick;
    logic b_loop_tick;
    logic b_powered;
    logic b_locked;

    // Slow clock as a one-cycle enable; the output pin is a registered square-ish copy.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            slow_cnt_q <= '0;
            slow_tick_q <= 1'b0;
        end else if (slow_cnt_q >= SLOW_CNT_W'(SLOW_CYCLES - 1)) begin
            slow_cnt_q <= '0;
            slow_tick_q <= 1'b1;
        end else begin
            slow_cnt_q <= slow_cnt_q + SLOW_CNT_W'(1);
            slow_tick_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            slow_clock <= 1'b0;
        end else begin
            slow_clock <= (slow_cnt_q < SLOW_CNT_W'(SLOW_CYCLES / 2));
        end
    end

    // The main clock arrives from a pin; it is synchronised and its rising edges become ticks.
    // Rates above half of mclk are undersampled, a limitation of the single-clock design.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            main_sync1_q <= 1'b0;
            main_sync2_q <= 1'b0;
            main_prev_q <= 1'b0;
        end else begin
            main_sync1_q <= main_clock;
            main_sync2_q <= main_sync1_q;
            main_prev_q <= main_sync2_q;
        end
    end

    assign main_tick = main_sync2_q && !main_prev_q;

    assign a_on_new = (first_loop_multiply_factor != '0) && first_loop_enable_bit;
    assign a_on_old = (a_mul_q != '0) && a_en_q;
    assign a_changed = (first_loop_divide_factor != a_div_q) || (first_loop_multiply_factor != a_mul_q)
        || (first_loop_enable_bit != a_en_q) || (first_loop_lock_wait_count != a_cnt_q);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            a_div_q <= DIV_RESET;
            a_mul_q <= MUL_RESET;
            a_en_q <= 1'b0;
            a_cnt_q <= CNT_RESET;
        end else if (first_loop_cfg_wr) begin
            a_div_q <= first_loop_divide_factor;
            a_mul_q <= first_loop_multiply_factor;
            a_en_q <= first_loop_enable_bit;
            a_cnt_q <= first_loop_lock_wait_count;
        end
    end

    // Software is expected to disable and wait before retuning; a direct retune still restarts the lock wait.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            a_start_q <= 1'b0;
            a_stop_q <= 1'b0;
        end else begin
            a_start_q <= first_loop_cfg_wr && a_on_new && (!a_on_old || a_changed);
            a_stop_q <= first_loop_cfg_wr && !a_on_new;
        end
    end

    assign b_on_new = (second_loop_multiply_factor != '0);
    assign b_changed = (second_loop_divide_factor != b_div_q) || (second_loop_multiply_factor != b_mul_q)
        || (second_loop_lock_wait_count != b_cnt_q) || (second_loop_source_sel != b_sel_q);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            b_div_q <= DIV_RESET;
            b_mul_q <= MUL_RESET;
            b_cnt_q <= CNT_RESET;
            b_sel_q <= SRC_MAIN_DIVIDED;
        end else if (second_loop_cfg_wr) begin
            b_div_q <= second_loop_divide_factor;
            b_mul_q <= second_loop_multiply_factor;
            b_cnt_q <= second_loop_lock_wait_count;
            b_sel_q <= second_loop_source_sel;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            b_start_q <= 1'b0;
            b_stop_q <= 1'b0;
        end else begin
            b_start_q <= second_loop_cfg_wr && b_on_new && ((b_mul_q == '0) || b_changed);
            b_stop_q <= second_loop_cfg_wr && !b_on_new;
        end
    end

    assign b_src_tick = (b_sel_q == SRC_FIRST_LOOP) ? a_loop_tick : main_tick;

    mult_loop #(
        .DIV_W(DIV_W),
        .MUL_W(MUL_W),
        .CNT_W(CNT_W)
    ) u_first_loop (
        .mclk(mclk),
        .rst_b(rst_b),
        .slow_tick(slow_tick_q),
        .src_tick(slow_tick_q),
        .div_val(a_div_q),
        .mul_val(a_mul_q),
        .count_val(a_cnt_q),
        .start_pulse(a_start_q),
        .stop_pulse(a_stop_q),
        .div_tick_q(a_div_tick),
        .loop_tick_q(a_loop_tick),
        .powered_q(a_powered),
        .locked_q(a_locked)
    );

    mult_loop #(
        .DIV_W(DIV_W),
        .MUL_W(MUL_W),
        .CNT_W(CNT_W)
    ) u_second_loop (
        .mclk(mclk),
        .rst_b(rst_b),
        .slow_tick(slow_tick_q),
        .src_tick(b_src_tick),
        .div_val(b_div_q),
        .mul_val(b_mul_q),
        .count_val(b_cnt_q),
        .start_pulse(b_start_q),
        .stop_pulse(b_stop_q),
        .div_tick_q(b_div_tick),
        .loop_tick_q(b_loop_tick),
        .powered_q(b_powered),
        .locked_q(b_locked)
    );

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            first_loop_div_out <= 1'b0;
            first_multiplier_loop <= 1'b0;
            first_loop_powered <= 1'b0;
            first_loop_locked_flag <= 1'b0;
            second_loop_div_out <= 1'b0;
            second_multiplier_loop <= 1'b0;
            second_loop_powered <= 1'b0;
            second_loop_locked_flag <= 1'b0;
        end else begin
            first_loop_div_out <= a_div_tick;
            first_multiplier_loop <= a_loop_tick;
            first_loop_powered <= a_powered;
            first_loop_locked_flag <= a_locked;
            second_loop_div_out <= b_div_tick;
            second_multiplier_loop <= b_loop_tick;
            second_loop_powered <= b_powered;
            second_loop_locked_flag <= b_locked;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lock_irq <= 1'b0;
        end else begin
            lock_irq <= (a_locked && first_loop_lock_irq_en) || (b_locked && second_loop_lock_irq_en);
        end
    end

    // Helper counters of slow ticks since the last stop and start of the first loop.
    logic [1:0] a_stop_ticks_q;
    logic [CNT_W:0] a_lock_ticks_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            a_stop_ticks_q <= 2'h0;
        end else if (a_stop_q) begin
            a_stop_ticks_q <= 2'h0;
        end else if (slow_tick_q && a_stop_ticks_q != 2'h3) begin
            a_stop_ticks_q <= a_stop_ticks_q + 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            a_lock_ticks_q <= '0;
        end else if (a_start_q) begin
            a_lock_ticks_q <= '0;
        end else if (slow_tick_q && !a_lock_ticks_q[CNT_W]) begin
            a_lock_ticks_q <= a_lock_ticks_q + (CNT_W + 1)'(1);
        end
    end

    chk_div_zero_low: assert property (@(posedge mclk) disable iff (!rst_b)
        (a_div_q == '0)[*3] |-> (!first_loop_div_out && !first_multiplier_loop))
        else $error("first loop output active with zero divider");

    chk_div_write_only: assert property (@(posedge mclk) disable iff (!rst_b)
        !$past(first_loop_cfg_wr) |-> $stable(a_div_q))
        else $error("divider field changed without a write");

    chk_mul_zero_stop: assert property (@(posedge mclk) disable iff (!rst_b)
        (first_loop_cfg_wr && first_loop_multiply_factor == '0) |=> a_stop_q && !a_start_q)
        else $error("zero multiplier write did not disable the loop");

    chk_stop_delay: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(first_loop_powered) |-> (a_stop_ticks_q == STOP_DELAY_TICKS))
        else $error("loop shut down at the wrong slow tick");

    chk_reenable_power: assert property (@(posedge mclk) disable iff (!rst_b)
        a_start_q |-> ##3 first_loop_powered)
        else $error("loop not powered after re-enable");

    chk_lock_cleared: assert property (@(posedge mclk) disable iff (!rst_b)
        (a_start_q || a_stop_q) |-> ##2 !first_loop_locked_flag)
        else $error("lock flag not cleared on restart");

    chk_lock_count: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(first_loop_locked_flag) |->
            (a_lock_ticks_q == ((a_cnt_q == '0) ? (CNT_W + 1)'(1) : {1'b0, a_cnt_q})))
        else $error("lock set after the wrong number of slow ticks");

    chk_irq_raise: assert property (@(posedge mclk) disable iff (!rst_b)
        (first_loop_locked_flag && $past(first_loop_lock_irq_en)) |-> lock_irq)
        else $error("lock interrupt missing");

    chk_lock_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(first_loop_locked_flag) |-> $past(a_start_q || a_stop_q, 2))
        else $error("lock flag dropped without restart");

    chk_second_src: assert property (@(posedge mclk) disable iff (!rst_b)
        (b_sel_q == SRC_MAIN_DIVIDED && b_div_q != '0 && !main_tick)[*2] |=> !second_loop_div_out)
        else $error("second loop divider counted without a main clock edge");

endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
    import pll_pkg::*;
    // A short slow period keeps lock waits and divider sweeps brief.
    localparam int S = 8;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic main_clock = 1'b0;
    logic [DIV_WIDTH-1:0] d1 = 8'h00;
    logic [DIV_WIDTH-1:0] d2 = 8'h00;
    logic [MUL_WIDTH-1:0] m1 = 11'h000;
    logic [MUL_WIDTH-1:0] m2 = 11'h000;
    logic [CNT_WIDTH-1:0] c1 = 6'h00;
    logic [CNT_WIDTH-1:0] c2 = 6'h00;
    logic en1 = 1'b0;
    logic wr1 = 1'b0;
    logic wr2 = 1'b0;
    logic ie1 = 1'b0;
    logic ie2 = 1'b0;
    logic sel2 = 1'b0;
    logic slow;
    logic [1:0] dv;
    logic [1:0] lp;
    logic [1:0] pw;
    logic [1:0] lk;
    logic irq;
    logic [31:0] rs = 32'hE19FE21A;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_cyc = 0;
    int mc_div = 0;
    int ns = 0;
    int nd[2];
    int nl[2];
    int divs[3];

    pll_divider_lock_logic #(.SLOW_CYCLES(S)) dut_u (
        .mclk(mclk), .rst_b(rst_b), .main_clock(main_clock),
        .first_loop_divide_factor(d1), .first_loop_multiply_factor(m1),
        .first_loop_enable_bit(en1), .first_loop_lock_wait_count(c1),
        .first_loop_cfg_wr(wr1), .first_loop_lock_irq_en(ie1),
        .second_loop_divide_factor(d2), .second_loop_multiply_factor(m2),
        .second_loop_lock_wait_count(c2), .second_loop_source_sel(sel2),
        .second_loop_cfg_wr(wr2), .second_loop_lock_irq_en(ie2),
        .slow_clock(slow), .first_loop_div_out(dv[0]), .first_multiplier_loop(lp[0]),
        .first_loop_powered(pw[0]), .first_loop_locked_flag(lk[0]),
        .second_loop_div_out(dv[1]), .second_multiplier_loop(lp[1]),
        .second_loop_powered(pw[1]), .second_loop_locked_flag(lk[1]),
        .lock_irq(irq)
    );

    always #10 mclk = ~mclk;

    // The main clock pin toggles every third cycle, a period of six cycles.
    always @(posedge mclk) begin
        #1;
        if (mc_div == 2) begin
            main_clock = ~main_clock;
            mc_div = 0;
        end else begin
            mc_div++;
        end
    end

    always @(posedge mclk) begin
        n_cyc++;
        if (n_cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge mclk);
            #1;
        end
    endtask

    // Counts are compared with a tolerance because divider phase is free after a write.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp, input int tol);
        logic ok;
        n_tests++;
        ok = (tol == 0) ? (seen === exp) : (seen + tol >= exp && seen <= exp + tol);
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    task automatic write(input int l, input int dvv, input int mv, input logic en, input int cv);
        if (l == 0) begin
            d1 = 8'(dvv);
            m1 = 11'(mv);
            en1 = en;
            c1 = 6'(cv);
            wr1 = 1'b1;
        end else begin
            d2 = 8'(dvv);
            m2 = 11'(mv);
            c2 = 6'(cv);
            wr2 = 1'b1;
        end
        cyc(1);
        wr1 = 1'b0;
        wr2 = 1'b0;
    endtask

    task automatic measure(input int n);
        nd = '{0, 0};
        nl = '{0, 0};
        ns = 0;
        repeat (n) begin
            cyc(1);
            ns += int'(slow);
            for (int i = 0; i < 2; i++) begin
                nd[i] += int'(dv[i]);
                nl[i] += int'(lp[i]);
            end
        end
    endtask

    // Counts of two or more keep the earliest possible lock clear of the powered check.
    task automatic start_lock(input int l, input int dvv, input int mv, input int cv);
        write(l, dvv, mv, 1'b1, cv);
        cyc(3);
        check("powered", pw[l], 1, 0);
        check("lock cleared", lk[l], 0, 0);
        cyc((cv - 1) * S - 1);
        check("early lock", lk[l], 0, 0);
        cyc(S + 3);
        check("locked", lk[l], 1, 0);
        check("lock irq", irq, (l == 0) ? ie1 : ie2, 0);
    endtask

    task automatic stop_chk(input int l, input int mv, input logic en);
        write(l, (l == 0) ? d1 : d2, mv, en, 0);
        cyc(S + 1);
        check("stop delay", pw[l], 1, 0);
        cyc(S + 3);
        check("stopped", pw[l], 0, 0);
        check("lock after stop", lk[l], 0, 0);
        measure(4 * S);
        check("pulses when off", nl[l], 0, 0);
    endtask

    initial begin
        cyc(4);
        rst_b = 1'b1;
        measure(4 * S);
        check("slow clock high", ns, 2 * S, 0);
        for (int i = 0; i < 2; i++) begin
            check("reset powered", pw[i], 0, 0);
            check("reset lock", lk[i], 0, 0);
            check("reset div pulses", nd[i] + nl[i], 0, 0);
        end
        write(0, 0, 5, 1'b1, 2);
        measure(6 * S);
        check("zero div out", nd[0], 0, 0);
        check("zero div loop", nl[0], 0, 0);
        rs = lfsr(rs);
        ie1 = rs[0];
        start_lock(0, 2, 5, int'(rs[7:4]) % 6 + 2);
        cyc(4 * S);
        check("lock held", lk[0], 1, 0);
        measure(16 * S);
        check("slow source div", nd[0], 8, 1);
        check("first rate", nl[0], 48, 2);
        rs = lfsr(rs);
        divs = '{1, int'(rs[5:0]) + 3, 255};
        foreach (divs[i]) begin
            write(0, divs[i], 1, 1'b1, 2);
            cyc(3);
            check("lock on change", lk[0], 0, 0);
            measure(3 * divs[i] * S);
            check("divider range", nd[0], 3, 1);
            check("divided rate", nl[0], 6, 2);
        end
        stop_chk(0, 0, 1'b1);
        start_lock(0, 1, 3, 2);
        stop_chk(0, 3, 1'b0);
        ie1 = 1'b0;
        ie2 = 1'b1;
        sel2 = SRC_MAIN_DIVIDED;
        start_lock(1, 3, 1, 2);
        measure(360);
        check("main source div", nd[1], 20, 2);
        check("second rate", nl[1], 40, 3);
        ie2 = 1'b0;
        start_lock(0, 2, 5, 2);
        sel2 = SRC_FIRST_LOOP;
        write(1, 3, 1, 1'b1, 2);
        cyc(8);
        measure(16 * S);
        check("chained source div", nd[1], 16, 2);
        check("chained rate", nl[1], 32, 3);
        stop_chk(1, 0, 1'b1);
        stop_test();
    end
endmodule
